// ---- design/fwid_core.sv ----
// Serial flash read path: wrap-around burst reads and the three ID readout commands.
`timescale 1ns/100ps
`include "fwid_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module fwid_core
    import fwid_pkg::*;
#(
    parameter logic [7:0]  MAKER_ID  = 8'h5A,   // Arbitrary value.
    parameter logic [7:0]  DEVICE_ID = 8'h3C,   // Arbitrary value.
    parameter logic [15:0] TYPE_CAP  = 16'hA55A // Arbitrary value.
) (
    // System clock and reset.
    input  wire logic                 mclk_i,
    input  wire logic                 reset_n_i,
    // Serial link, clocked by the host's serial clock.
    input  wire logic                 sck_i,
    input  wire logic                 cs_n_i,
    input  wire logic [3:0]           io_i,
    output logic      [3:0]           io_o,
    output logic      [3:0]           io_oe_o,
    // Mode and status from the rest of the device.
    input  wire logic                 quad_instruction_mode_i,
    input  wire logic                 write_in_progress_flag_i,
    // Array read port, link domain.
    output fwid_pkg::fwid_addr_t      mem_addr_o,
    input  wire logic [7:0]           mem_data_i,
    // Read parameter state, system domain; busy flag, link domain.
    output logic                      wrap_enable_bit_o,
    output logic [1:0]                burst_len_sel_o,
    output logic                      busy_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Link domain. The instruction, address and output logic is held in reset while chip select is high.
    wire link_rst_n = reset_n_i & ~cs_n_i;

    logic                  quad_l;
    fwid_pkg::fwid_addr_t  addr;
    fwid_pkg::fwid_op_e    op;
    logic [7:0]            sh_in;
    logic [2:0]            bit_cnt;
    logic [7:0]            byte_cnt;
    logic                  out_phase;
    logic [7:0]            out_byte;
    logic [1:0]            id_idx;
    logic [2:0]            param;
    logic                  param_tgl;
    logic [2:0]            param_val;
    logic [7:0]            shift_out;
    logic [3:0]            nib_cnt;
    logic                  mdid_swap;
    logic                  wip_l;
    logic                  wrap_l;
    logic [1:0]            len_l;

    fwid_sync #(.WIDTH(5)) u_link_sync (
        .clk_i     (sck_i),
        .reset_n_i (reset_n_i),
        .d_i       ({quad_instruction_mode_i, write_in_progress_flag_i, param}),
        .q_o       ({quad_l, wip_l, wrap_l, len_l})
    );
    // Length bits cross as a set with the enable bit; they only change between frames.
    wire [1:0] len_sel_l = len_l;

    // Quad mode takes a nibble per edge, serial mode one bit.
    wire        quad_now    = quad_l;
    wire [7:0]  next_sh_in  = quad_now ? {sh_in[3:0], io_i} : {sh_in[6:0], io_i[0]};
    wire        byte_done   = quad_now ? bit_cnt[0] : (bit_cnt == 3'h7);
    wire [7:0]  next_byte   = next_sh_in;
    wire        in_cmd      = (byte_cnt == 8'h00);

    // Instruction decode.
    wire        is_std_id   = (next_byte == `FWID_CMD_STD_ID) ||
                              ((next_byte == `FWID_CMD_STD_ID_QUAD) && quad_now);
    wire        is_legacy   = (next_byte == `FWID_CMD_LEGACY_ID) && !wip_l;
    wire        is_read     = (next_byte == `FWID_CMD_READ) || (next_byte == `FWID_CMD_FAST_READ);
    fwid_pkg::fwid_op_e next_op;
    assign next_op = is_std_id ? FWID_OP_STD_ID :
                     is_legacy ? FWID_OP_LEGACY_ID :
                     (next_byte == `FWID_CMD_MAKER_DEV_ID) ? FWID_OP_MAKER_DEV_ID :
                     (next_byte == `FWID_CMD_READ_PARAM_SET) ? FWID_OP_PARAM :
                     is_read ? FWID_OP_READ : FWID_OP_NONE;

    // Number of input bytes after the instruction before output starts.
    wire [7:0] hdr_len = (op == FWID_OP_LEGACY_ID)    ? 8'(`FWID_LEGACY_DUMMY_BYTES) :
                         (op == FWID_OP_MAKER_DEV_ID) ? 8'(`FWID_MDID_DUMMY_BYTES + 1) :
                         (op == FWID_OP_READ)         ? 8'(`FWID_ADDR_BYTES + `FWID_FAST_DUMMY_BYTES) :
                         8'h00;
    wire hdr_last = byte_done && !in_cmd && (byte_cnt == hdr_len);

    // Wrap addressing applies to every read instruction.
    fwid_pkg::fwid_addr_t next_addr;
    fwid_wrap_addr u_wrap (
        .addr_i      (addr),
        .wrap_en_i   (wrap_l),
        .len_sel_i   (len_sel_l),
        .next_addr_o (next_addr)
    );

    // Byte to shift out next.
    wire [7:0] std_byte  = (id_idx == 2'h0) ? MAKER_ID : (id_idx == 2'h1) ? TYPE_CAP[15:8] : TYPE_CAP[7:0];
    wire [7:0] mdid_byte = (id_idx[0] ^ mdid_swap) ? DEVICE_ID : MAKER_ID;
    wire [7:0] load_byte = (op == FWID_OP_STD_ID)       ? std_byte :
                           (op == FWID_OP_LEGACY_ID)    ? DEVICE_ID :
                           (op == FWID_OP_MAKER_DEV_ID) ? mdid_byte : mem_data_i;
    wire [1:0] next_id_idx = (op == FWID_OP_STD_ID) ?
                             ((id_idx == 2'(`FWID_STD_ID_BYTES - 1)) ? 2'h0 : 2'(id_idx + 2'h1)) :
                             2'(id_idx + 2'h1);

    // Rising edge: capture instruction, address and dummy bits.
    always_ff @(posedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            sh_in     <= 8'h00;
            bit_cnt   <= 3'h0;
            byte_cnt  <= 8'h00;
            op        <= FWID_OP_NONE;
            addr      <= 24'h000000;
            mdid_swap <= 1'b0;
        end else if (!out_phase) begin
            sh_in   <= next_sh_in;
            bit_cnt <= byte_done ? 3'h0 : 3'(bit_cnt + 3'h1);
            if (byte_done) begin
                byte_cnt <= 8'(byte_cnt + 8'h01);
                if (in_cmd) begin
                    op <= next_op;
                end
                if (op == FWID_OP_READ && byte_cnt <= 8'(`FWID_ADDR_BYTES)) begin
                    addr <= {addr[15:0], next_byte};
                end
                if (op == FWID_OP_MAKER_DEV_ID && hdr_last) begin
                    mdid_swap <= next_byte[0];
                end
            end
        end else if (op == FWID_OP_READ && nib_cnt == 4'h1) begin
            addr <= next_addr;
        end
    end

    // Read-parameter capture survives chip select; only the device reset clears it.
    wire param_take = !out_phase && byte_done && (op == FWID_OP_PARAM) && (byte_cnt == 8'h01);

    always_ff @(posedge sck_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            param_tgl <= 1'b0;
            param_val <= `FWID_PARAM_RESET;
        end else if (param_take) begin
            param_val <= next_byte[2:0];
            param_tgl <= ~param_tgl;
        end
    end

    // Output starts on the falling edge that follows the last header bit.
    wire out_op    = (op == FWID_OP_READ) || (op == FWID_OP_STD_ID) || (op == FWID_OP_LEGACY_ID) ||
                     (op == FWID_OP_MAKER_DEV_ID);
    wire out_start = !out_phase && out_op && (byte_cnt == 8'(hdr_len + 8'h01));

    // Falling edge: shift data out, MSB first.
    always_ff @(negedge sck_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            out_phase <= 1'b0;
            shift_out <= 8'h00;
            nib_cnt   <= 4'h0;
            id_idx    <= 2'h0;
            io_o      <= 4'h0;
            io_oe_o   <= 4'h0;
        end else if (out_phase) begin
            if (nib_cnt == (quad_now ? 4'h1 : 4'h7)) begin
                nib_cnt   <= 4'h0;
                shift_out <= load_byte;
                id_idx    <= next_id_idx;
            end else begin
                nib_cnt   <= 4'(nib_cnt + 4'h1);
                shift_out <= quad_now ? {shift_out[3:0], 4'h0} : {shift_out[6:0], 1'b0};
            end
            io_o    <= quad_now ? shift_out[7:4] : {2'b00, shift_out[7], 1'b0};
            io_oe_o <= quad_now ? 4'hF : 4'h2;
        end else if (out_start) begin
            out_phase <= 1'b1;
            nib_cnt   <= 4'h1;
            shift_out <= quad_now ? {load_byte[3:0], 4'h0} : {load_byte[6:0], 1'b0};
            id_idx    <= 2'h1;
            io_o      <= quad_now ? load_byte[7:4] : {2'b00, load_byte[7], 1'b0};
            io_oe_o   <= quad_now ? 4'hF : 4'h2;
        end
    end

    assign mem_addr_o = addr;
    assign busy_o     = out_phase;

    ////////////////////////////////////////////////////////////////////////////
    // System domain: the read parameters live here, updated by a toggle crossing.
    logic       tgl_s;
    logic       tgl_d;
    logic [2:0] param_sys;

    fwid_sync #(.WIDTH(1)) u_tgl_sync (
        .clk_i     (mclk_i),
        .reset_n_i (reset_n_i),
        .d_i       (param_tgl),
        .q_o       (tgl_s)
    );

    // The captured value has been stable for two clocks by the time its toggle arrives.
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tgl_d     <= 1'b0;
            param_sys <= `FWID_PARAM_RESET;
        end else begin
            tgl_d <= tgl_s;
            if (tgl_s != tgl_d) begin
                param_sys <= param_val;
            end
        end
    end

    assign param = param_sys;
    assign wrap_enable_bit_o = param_sys[`FWID_PARAM_WRAP_EN_BIT];
    assign burst_len_sel_o   = param_sys[1:0];

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the link and on the read parameters.

    // Deselect stops all drive at once.
    a_oe_off_deselect: assert property (
        @(posedge mclk_i) disable iff (!reset_n_i)
        cs_n_i |-> (io_oe_o == 4'h0)) else $error("output driven while deselected");

    // Deselect ends the output phase.
    a_busy_off_deselect: assert property (
        @(posedge mclk_i) disable iff (!reset_n_i)
        cs_n_i |-> !out_phase) else $error("output phase while deselected");

    // Read parameters only change on a crossing toggle.
    a_param_hold: assert property (
        @(posedge mclk_i) disable iff (!reset_n_i)
        (tgl_s == tgl_d) |=> $stable(param_sys)) else $error("read parameters changed without command");

    // A crossing toggle installs the captured value.
    a_param_take: assert property (
        @(posedge mclk_i) disable iff (!reset_n_i)
        (tgl_s != tgl_d) |=> (param_sys == $past(param_val))) else $error("read parameters not installed");

    // Legacy ID is refused while a write is in progress.
    a_legacy_busy: assert property (
        @(posedge sck_i) disable iff (!link_rst_n)
        (!out_phase && byte_done && in_cmd && wip_l) |=> (op != FWID_OP_LEGACY_ID)) else $error("legacy id taken while busy");

    // The quad-only ID code is refused in serial mode.
    a_quad_only_code: assert property (
        @(posedge sck_i) disable iff (!link_rst_n)
        (!out_phase && byte_done && in_cmd && !quad_now && (next_byte == `FWID_CMD_STD_ID_QUAD))
        |=> (op == FWID_OP_NONE)) else $error("quad-only id code taken in serial mode");

    // The standard ID index stays within its three bytes.
    a_std_id_cycle: assert property (
        @(negedge sck_i) disable iff (!link_rst_n)
        (out_phase && (op == FWID_OP_STD_ID)) |-> (id_idx != 2'h3)) else $error("standard id index out of range");

    // A wrap burst never leaves its aligned 64-byte block.
    a_wrap_page: assert property (
        @(posedge sck_i) disable iff (!link_rst_n)
        (out_phase && (op == FWID_OP_READ) && wrap_l) |-> (next_addr[23:6] == addr[23:6]))
        else $error("wrap burst left its boundary");

    // Without wrap the address steps by one.
    a_linear_step: assert property (
        @(posedge sck_i) disable iff (!link_rst_n)
        (out_phase && (op == FWID_OP_READ) && !wrap_l) |-> (next_addr == 24'(addr + 24'h1)))
        else $error("linear read did not step by one");

    // The first output edge drives the line.
    a_first_bit_drive: assert property (
        @(negedge sck_i) disable iff (!link_rst_n)
        out_start |=> (io_oe_o != 4'h0)) else $error("output not driven after header");

endmodule : fwid_core

// ---- design/fwid_regs.svh ----
// Command codes, field positions, reset values and timing counts of the flash read-path block.
`ifndef FWID_REGS_SVH
`define FWID_REGS_SVH

`define FWID_CMD_READ_PARAM_SET   8'hC0
`define FWID_CMD_LEGACY_ID        8'hAB
`define FWID_CMD_STD_ID           8'h9F
`define FWID_CMD_STD_ID_QUAD      8'hAF
`define FWID_CMD_MAKER_DEV_ID     8'h90
`define FWID_CMD_READ             8'h03
`define FWID_CMD_FAST_READ        8'h0B

`define FWID_PARAM_LEN_LO_BIT     0
`define FWID_PARAM_LEN_HI_BIT     1
`define FWID_PARAM_WRAP_EN_BIT    2
`define FWID_PARAM_RESET          3'h0

`define FWID_LEGACY_DUMMY_BYTES   3
`define FWID_MDID_DUMMY_BYTES     2
`define FWID_ADDR_BYTES           3
`define FWID_FAST_DUMMY_BYTES     1
`define FWID_STD_ID_BYTES         3
`define FWID_PAGE_BYTES           256

`endif

// ---- design/fwid_pkg.sv ----
// Types shared by the flash read-path block.
package fwid_pkg;

    typedef enum logic [2:0] {
        FWID_OP_NONE,
        FWID_OP_READ,
        FWID_OP_LEGACY_ID,
        FWID_OP_STD_ID,
        FWID_OP_MAKER_DEV_ID,
        FWID_OP_PARAM
    } fwid_op_e;

    typedef logic [23:0] fwid_addr_t;

endpackage : fwid_pkg

// ---- design/fwid_sync.sv ----
// Two-flop level synchroniser.
`timescale 1ns/100ps
module fwid_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset.
    input  wire logic             clk_i,
    input  wire logic             reset_n_i,
    // Level in and out.
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= d_i;
            q_o  <= meta;
        end
    end

endmodule : fwid_sync

// ---- design/fwid_wrap_addr.sv ----
// Next read address under linear or wrap-around burst addressing.
`timescale 1ns/100ps
module fwid_wrap_addr
    import fwid_pkg::*;
(
    // Current address and mode.
    input  wire fwid_pkg::fwid_addr_t addr_i,
    input  wire logic                 wrap_en_i,
    input  wire logic [1:0]           len_sel_i,
    // Next address.
    output fwid_pkg::fwid_addr_t      next_addr_o
);

    // Mask of the low address bits that count inside the burst: 8, 16, 32 or 64 bytes.
    wire fwid_addr_t low_mask = wrap_en_i ? fwid_addr_t'((24'h8 << len_sel_i) - 24'h1)
                                          : 24'hFFFFFF;
    wire fwid_addr_t inc_addr = addr_i + 24'h1;

    // The aligned boundary block keeps its high bits; the low bits count modulo the length.
    assign next_addr_o = (addr_i & ~low_mask) | (inc_addr & low_mask);

endmodule : fwid_wrap_addr

// ---- tb/fwid_host_model.sv ----
// Host-side serial controller model that frames commands and captures returned bytes.
`timescale 1ns/100ps
module fwid_host_model (
    // Serial link.
    output logic       sck_o,
    output logic       cs_n_o,
    output logic [3:0] io_o,
    // Device serial output and its enable.
    input  wire logic  sdo_i,
    input  wire logic  sdo_oe_i
);
    logic [7:0] rx [0:15];
    logic       saw_oe;
    logic       last;

    initial begin
        sck_o  = 1'b0;
        cs_n_o = 1'b1;
        io_o   = 4'hA;
        last   = 1'b0;
        saw_oe = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // The clock stands low outside frames; input data changes only while it is low.
    task automatic frame(input logic [7:0] cmd, input logic [31:0] hdr, input int nhdr, input int nrd);
        logic [39:0] sh;
        sh     = {cmd, hdr << (8 * (4 - nhdr))};
        saw_oe = 1'b0;
        cs_n_o = 1'b0;
        for (int i = 0; i < 8 * (nhdr + 1); i++) begin
            io_o[0] = sh[39 - i];
            #32 sck_o = 1'b1;
            #32 sck_o = 1'b0;
        end
        for (int i = 0; i < 8 * nrd; i++) begin
            io_o = ~io_o;
            #32 sck_o = 1'b1;
            saw_oe = saw_oe | sdo_oe_i;
            last = sdo_oe_i ? sdo_i : ~last;
            rx[i / 8] = {rx[i / 8][6:0], last};
            #32 sck_o = 1'b0;
        end
        #32 cs_n_o = 1'b1;
        io_o = ~io_o;
        #100;
    endtask : frame
endmodule : fwid_host_model

// ---- tb/fwid_core_bench.sv ----
// Self-checking bench for the flash read path: read parameters, wrap bursts and ID readouts.
`timescale 1ns/100ps
module fwid_core_bench;
    import fwid_pkg::*;
    localparam logic [7:0]  MAKER = 8'h5A;    // Arbitrary value.
    localparam logic [7:0]  DEV   = 8'h3C;    // Arbitrary value.
    localparam logic [15:0] TCAP  = 16'hA55A; // Arbitrary value.
    logic       mclk_i;
    logic       reset_n_i;
    logic       sck;
    logic       cs_n;
    logic       write_in_progress_flag;
    logic [3:0] io_in;
    logic [3:0] io_out;
    logic [3:0] io_oe;
    fwid_addr_t mem_addr;
    logic [7:0] mem_data;
    logic       wrap_en;
    logic [1:0] len_sel;
    logic       busy;
    int         n_errors;
    int         samples_checked;

    always #2 mclk_i = ~mclk_i;
    assign mem_data = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5C;

    fwid_core #(.MAKER_ID(MAKER), .DEVICE_ID(DEV), .TYPE_CAP(TCAP)) u_fwid_core (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .sck_i(sck), .cs_n_i(cs_n), .io_i(io_in),
        .io_o(io_out), .io_oe_o(io_oe), .quad_instruction_mode_i(1'b0), .write_in_progress_flag_i(write_in_progress_flag),
        .mem_addr_o(mem_addr), .mem_data_i(mem_data), .wrap_enable_bit_o(wrap_en),
        .burst_len_sel_o(len_sel), .busy_o(busy));
    fwid_host_model u_fwid_host_model (
        .sck_o(sck), .cs_n_o(cs_n), .io_o(io_in), .sdo_i(io_out[1]), .sdo_oe_i(io_oe[1]));

    ////////////////////////////////////////////////////////////////////////////
    function automatic logic [23:0] nth(input logic [23:0] a, input int k, input logic [2:0] p);
        logic [23:0] m;
        logic [23:0] s;
        m = (24'h000008 << p[1:0]) - 24'h000001;
        s = a + k[23:0];
        return p[2] ? ((a & ~m) | (s & m)) : s;
    endfunction : nth

    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic test_done;
        $display("checks %0d, mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done

    task automatic do_reset;
        @(negedge mclk_i) reset_n_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        reset_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
    endtask : do_reset

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [23:0] a;
        mclk_i = 1'b0;
        reset_n_i = 1'b0;
        write_in_progress_flag = 1'b0;
        n_errors = 0;
        samples_checked = 0;
        do_reset();
        chk("wrap enable after reset", 24'h0, wrap_en);
        // Every parameter value, each followed by a read that starts near a page end.
        for (int d = 0; d < 8; d++) begin
            u_fwid_host_model.frame(8'hC0, d, 1, 0);
            repeat (8) @(negedge mclk_i);
            chk("wrap enable", d[2], wrap_en);
            chk("length select", d[1:0], len_sel);
            u_fwid_host_model.frame(d[0] ? 8'h0B : 8'h03, 32'h0000FE00, 4, 12);
            for (int k = 0; k < 12; k++) begin
                a = nth(24'h0000FE, k, d[2:0]);
                chk("burst byte", a[7:0] ^ a[15:8] ^ 8'h5C, u_fwid_host_model.rx[k]);
            end
            chk("drive after deselect", 24'h0, io_oe);
            chk("busy after deselect", 24'h0, busy);
        end
        $display("test burst done");
        u_fwid_host_model.frame(8'hAB, 32'h0, 3, 3);
        for (int k = 0; k < 3; k++) begin
            chk("legacy id", DEV, u_fwid_host_model.rx[k]);
        end
        u_fwid_host_model.frame(8'h9F, 32'h0, 0, 6);
        for (int k = 0; k < 6; k++) begin
            chk("std id", (k % 3 == 0) ? MAKER : (k % 3 == 1) ? TCAP[15:8] : TCAP[7:0],
                u_fwid_host_model.rx[k]);
        end
        for (int b = 0; b < 2; b++) begin
            u_fwid_host_model.frame(8'h90, b, 3, 4);
            for (int k = 0; k < 4; k++) begin
                chk("maker dev id", ((k + b) % 2) ? DEV : MAKER, u_fwid_host_model.rx[k]);
            end
        end
        u_fwid_host_model.frame(8'hAF, 32'h0, 0, 2);
        chk("quad-only id drive", 24'h0, u_fwid_host_model.saw_oe);
        @(negedge mclk_i) write_in_progress_flag = 1'b1;
        u_fwid_host_model.frame(8'hAB, 32'h0, 3, 2);
        chk("busy legacy drive", 24'h0, u_fwid_host_model.saw_oe);
        @(negedge mclk_i) write_in_progress_flag = 1'b0;
        $display("test id done");
        do_reset();
        chk("wrap enable after mid-run reset", 24'h0, wrap_en);
        $display("test reset done");
        test_done();
    end

    initial begin
        #300000;
        n_errors++;
        test_done();
    end
endmodule : fwid_core_bench
